// ### dbc_break_cmp.sv
// top of the pc and data breakpoint comparator
// assumes one 10 MHz clock, bus strobes synchronous and one cycle wide
`timescale 1ns/100ps
`include "dbc_cfg.svh"
module dbc_break_cmp (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // debug register write, from supervisor instruction
  input  wire logic        sw_wr_in,
  input  wire logic [3:0]  sw_reg_in,
  input  wire logic [31:0] sw_data_in,
  // debugger register commands over the background debug port
  input  wire logic        dbg_wr_in,
  input  wire logic        dbg_rd_in,
  input  wire logic [3:0]  dbg_reg_in,
  input  wire logic [31:0] dbg_data_in,
  output logic [31:0]      dbg_rd_data_out,
  output logic             dbg_rd_valid_out,
  // debugger memory access data captured into the value register
  input  wire logic        dbg_mem_in,
  input  wire logic [31:0] dbg_mem_data_in,
  // trigger definition bits of one level
  input  wire logic [9:0]  trigger_definition_in,
  // processor pc and local bus transfer
  input  wire logic        pc_valid_in,
  input  wire logic [31:0] pc_in,
  input  wire logic        bus_valid_in,
  input  wire logic [31:0] bus_data_in,
  input  wire logic [1:0]  bus_addr_lo_in,
  input  wire logic [1:0]  bus_size_in,
  // registered condition results
  output logic             pc_hit_out,
  output logic             data_hit_out
);
  dbc_pkg::dbc_state_t st_r;
  dbc_pkg::dbc_state_t st_nxt;
  logic                data_match;
  logic                pc_eq;

  ////////////////////////////////////////////////////////////////////////////
  // data comparator
  dbc_data_lane #(
    .W (32)
  ) u_lane (
    .value_in    (st_r.data_val),
    .mask_in     (st_r.data_mask),
    .bus_data_in (bus_data_in),
    .addr_lo_in  (bus_addr_lo_in),
    .size_in     (bus_size_in),
    .lane_en_in  (trigger_definition_in[`DBC_TD_EN_LONG:`DBC_TD_EN_BYTE3]),
    .invert_in   (trigger_definition_in[`DBC_TD_DATA_INV]),
    .hit_out     (data_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // masked pc compare, mask one drops the bit
  assign pc_eq = ((st_r.pc_addr ^ pc_in) & ~st_r.pc_mask) == 32'h00000000;

  // next state: writes, readback, conditions
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    // software writes win over debugger writes in the same cycle
    if (dbg_wr_in)
    begin
      unique case (dbg_reg_in)
        `DBC_REG_PC_ADDR:   st_nxt.pc_addr   = dbg_data_in;
        `DBC_REG_PC_MASK:   st_nxt.pc_mask   = dbg_data_in;
        `DBC_REG_DATA_VAL:  st_nxt.data_val  = dbg_data_in;
        `DBC_REG_DATA_MASK: st_nxt.data_mask = dbg_data_in;
        default: ;
      endcase
    end
    if (sw_wr_in)
    begin
      unique case (sw_reg_in)
        `DBC_REG_PC_ADDR:   st_nxt.pc_addr   = sw_data_in;
        `DBC_REG_PC_MASK:   st_nxt.pc_mask   = sw_data_in;
        `DBC_REG_DATA_VAL:  st_nxt.data_val  = sw_data_in;
        `DBC_REG_DATA_MASK: st_nxt.data_mask = sw_data_in;
        default: ;
      endcase
    end
    // debug memory access reuses the value register as its data buffer
    if (dbg_mem_in)
      st_nxt.data_val = dbg_mem_data_in;
    // only address and value read back; masks are write-only, reads give zero
    if (dbg_rd_in)
    begin
      st_nxt.rd_valid = 1'b1;
      unique case (dbg_reg_in)
        `DBC_REG_PC_ADDR:  st_nxt.rd_data = st_r.pc_addr;
        `DBC_REG_DATA_VAL: st_nxt.rd_data = st_r.data_val;
        default:           st_nxt.rd_data = `DBC_WORD_RESET;
      endcase
    end
    // pc condition, inverted sense selects outside the region
    st_nxt.pc_hit   = pc_valid_in & trigger_definition_in[`DBC_TD_PC_EN]
                    & (pc_eq ^ trigger_definition_in[`DBC_TD_PC_INV]);
    st_nxt.data_hit = bus_valid_in & data_match;
  end

  // registers; pattern contents stay undefined in meaning until programmed
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r.pc_addr   <= `DBC_WORD_RESET;
      st_r.pc_mask   <= `DBC_WORD_RESET;
      st_r.data_val  <= `DBC_WORD_RESET;
      st_r.data_mask <= `DBC_WORD_RESET;
      st_r.rd_data   <= `DBC_WORD_RESET;
      st_r.rd_valid  <= 1'b0;
      st_r.pc_hit    <= 1'b0;
      st_r.data_hit  <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign dbg_rd_data_out  = st_r.rd_data;
  assign dbg_rd_valid_out = st_r.rd_valid;
  assign pc_hit_out       = st_r.pc_hit;
  assign data_hit_out     = st_r.data_hit;

  ////////////////////////////////////////////////////////////////////////////
  // checks: each one looks at most one cycle ahead, quiet while reset is held

  // pc sample inside the region, plain sense
  sequence s_pc_inside;
    pc_valid_in && trigger_definition_in[`DBC_TD_PC_EN] && !trigger_definition_in[`DBC_TD_PC_INV] && pc_eq;
  endsequence

  // pc sample outside the region, plain sense
  sequence s_pc_outside;
    pc_valid_in && trigger_definition_in[`DBC_TD_PC_EN] && !trigger_definition_in[`DBC_TD_PC_INV] && !pc_eq;
  endsequence

  // pc sample with the inverted sense selected
  sequence s_pc_inverted;
    pc_valid_in && trigger_definition_in[`DBC_TD_PC_EN] && trigger_definition_in[`DBC_TD_PC_INV];
  endsequence

  // debugger write of the pc address that no software write overrides
  sequence s_dbg_pc_wr;
    dbg_wr_in && dbg_reg_in == `DBC_REG_PC_ADDR && !(sw_wr_in && sw_reg_in == `DBC_REG_PC_ADDR);
  endsequence

  // long transfer equal to the pattern under the mask
  sequence s_long_equal;
    bus_valid_in && bus_size_in == `DBC_SZ_LONG && trigger_definition_in[`DBC_TD_EN_LONG]
      && ((bus_data_in ^ st_r.data_val) & ~st_r.data_mask) == 32'h00000000;
  endsequence

  // byte at address 00 matching on the top lane, plain sense
  sequence s_byte_top;
    bus_valid_in && bus_size_in == `DBC_SZ_BYTE && bus_addr_lo_in == 2'h0
      && trigger_definition_in[`DBC_TD_EN_BYTE3] && !trigger_definition_in[`DBC_TD_DATA_INV]
      && ((bus_data_in[31:24] ^ st_r.data_val[31:24]) & ~st_r.data_mask[31:24]) == 8'h00;
  endsequence

  // word in the low half while only the upper word lane is enabled
  sequence s_word_low_upper_en;
    bus_valid_in && bus_size_in == `DBC_SZ_WORD && bus_addr_lo_in[1]
      && trigger_definition_in[`DBC_TD_EN_LONG:`DBC_TD_EN_BYTE3] == 7'h10;
  endsequence

  // pc region: plain sense hits inside only, inverted sense outside only
  a_pc_hit_in: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_pc_inside |=> pc_hit_out)
    else $error("pc hit missing inside region");
  a_pc_hit_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_pc_outside |=> !pc_hit_out)
    else $error("pc hit outside region");
  a_pc_invert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_pc_inverted |=> pc_hit_out == !$past(pc_eq))
    else $error("pc invert sense wrong");
  a_pc_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !trigger_definition_in[`DBC_TD_PC_EN] |=> !pc_hit_out)
    else $error("pc hit while pc breakpoint off");

  // pc mask extremes
  a_pc_mask_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.pc_mask == 32'h00000000 && pc_in != st_r.pc_addr) |-> !pc_eq)
    else $error("unmasked pc compare mismatch");
  a_pc_mask_all: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.pc_mask == 32'hFFFFFFFF) |-> pc_eq)
    else $error("fully masked pc must match");

  // register writes and readback
  a_pc_wr_take: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (sw_wr_in && sw_reg_in == `DBC_REG_PC_ADDR) |=> st_r.pc_addr == $past(sw_data_in))
    else $error("pc address write lost");
  a_pc_dbg_wr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_dbg_pc_wr |=> st_r.pc_addr == $past(dbg_data_in))
    else $error("debugger pc address write lost");
  a_pc_mask_rd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (dbg_rd_in && dbg_reg_in == `DBC_REG_PC_MASK) |=> dbg_rd_valid_out && dbg_rd_data_out == 32'h00000000)
    else $error("mask must not read back");
  a_data_mask_rd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (dbg_rd_in && dbg_reg_in == `DBC_REG_DATA_MASK) |=> dbg_rd_valid_out && dbg_rd_data_out == 32'h00000000)
    else $error("data mask must not read back");
  a_val_rd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (dbg_rd_in && dbg_reg_in == `DBC_REG_DATA_VAL) |=> dbg_rd_data_out == $past(st_r.data_val))
    else $error("value readback wrong");
  a_rd_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !dbg_rd_in |=> !dbg_rd_valid_out)
    else $error("read valid without a read");
  a_mem_overwrite: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    dbg_mem_in |=> st_r.data_val == $past(dbg_mem_data_in))
    else $error("debug memory access did not overwrite value");

  // data comparator: enables, idle bus, sense and lanes
  a_data_no_en: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (trigger_definition_in[`DBC_TD_EN_LONG:`DBC_TD_EN_BYTE3] == 7'h00) |=> !data_hit_out)
    else $error("data hit with no lane enabled");
  a_data_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !bus_valid_in |=> !data_hit_out)
    else $error("data hit without a transfer");
  a_data_long: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_long_equal ##0 !trigger_definition_in[`DBC_TD_DATA_INV] |=> data_hit_out)
    else $error("long data match missed");
  a_data_long_inv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_long_equal ##0 trigger_definition_in[`DBC_TD_DATA_INV] |=> !data_hit_out)
    else $error("inverted long data hit on equality");
  a_byte_top: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_byte_top |=> data_hit_out)
    else $error("top byte lane match missed");
  a_word_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_word_low_upper_en |=> !data_hit_out)
    else $error("low word hit on the upper word lane");
endmodule : dbc_break_cmp

// ### dbc_bus_model.sv
// processor side model: pc samples and local bus transfers
// assumes callers may enter xfer at any time; it launches at the next falling edge
`timescale 1ns/100ps
module dbc_bus_model (
  // clock
  input  wire logic   clk_in,
  // pc sample and bus transfer
  output logic        pc_valid_out,
  output logic [31:0] pc_out,
  output logic        bus_valid_out,
  output logic [31:0] bus_data_out,
  output logic [1:0]  bus_addr_lo_out,
  output logic [1:0]  bus_size_out
);
  ////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    {pc_valid_out, bus_valid_out} = 2'h0;
    {pc_out, bus_data_out} = 64'h0;
    {bus_addr_lo_out, bus_size_out} = 4'h0;
  end
  // one-cycle sample; operands already sit on their lanes
  // waiting first keeps the release and the next launch in different time steps
  task automatic xfer(input logic pv, input logic [31:0] pc, input logic bv,
                      input logic [31:0] d, input logic [1:0] a, input logic [1:0] sz);
    @(negedge clk_in);
    {pc_valid_out, pc_out, bus_valid_out, bus_data_out} = {pv, pc, bv, d};
    {bus_addr_lo_out, bus_size_out} = {a, sz};
    @(negedge clk_in);
    // released lines flip so a stale value can never match
    {pc_valid_out, bus_valid_out} = 2'h0;
    {pc_out, bus_data_out} = ~{pc_out, bus_data_out};
  endtask : xfer
endmodule : dbc_bus_model

// ### dbc_cfg.svh
// constants for the debug pc/data breakpoint comparator block
// assumes inclusion by the package and the design modules
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH
`define DBC_REG_PC_ADDR   4'h8
`define DBC_REG_PC_MASK   4'h9
`define DBC_REG_DATA_VAL  4'hE
`define DBC_REG_DATA_MASK 4'hF
// trigger definition field positions (one level); byte0 is bits 7:0, byte3 bits 31:24
`define DBC_TD_EN_LONG    9
`define DBC_TD_EN_WORD_LO 8
`define DBC_TD_EN_WORD_HI 7
`define DBC_TD_EN_BYTE0   6
`define DBC_TD_EN_BYTE1   5
`define DBC_TD_EN_BYTE2   4
`define DBC_TD_EN_BYTE3   3
`define DBC_TD_DATA_INV   2
`define DBC_TD_PC_EN      1
`define DBC_TD_PC_INV     0
// bus size encodings
`define DBC_SZ_LONG 2'h0
`define DBC_SZ_BYTE 2'h1
`define DBC_SZ_WORD 2'h2
`define DBC_WORD_RESET 32'h00000000
`endif

// ### dbc_data_lane.sv
// data lane comparator: masked compare of one bus transfer against the pattern
// assumes size and address are stable with the data strobe, in one clock
`timescale 1ns/100ps
`include "dbc_cfg.svh"
module dbc_data_lane #(
  parameter int W = 32
) (
  // pattern
  input  wire logic [W-1:0] value_in,
  input  wire logic [W-1:0] mask_in,
  // transfer
  input  wire logic [W-1:0] bus_data_in,
  input  wire logic [1:0]   addr_lo_in,
  input  wire logic [1:0]   size_in,
  // lane enables from the trigger definition: lw, wl, wu, ll, lm, um, uu
  input  wire logic [6:0]   lane_en_in,
  input  wire logic         invert_in,
  // result
  output logic              hit_out
);
  logic [3:0] byte_eq;
  logic [3:0] sel;
  logic       eq;
  logic       en;

  // per byte masked equality, byte 3 is bits 31:24
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      byte_eq[i] = ((value_in[i*8 +: 8] ^ bus_data_in[i*8 +: 8]) & ~mask_in[i*8 +: 8]) == 8'h00;
    end
  end

  // operand lanes by size and address; words ignore address bit 0, longs ignore the address
  always_comb
  begin
    unique case (size_in)
      `DBC_SZ_BYTE: sel = 4'h8 >> addr_lo_in;
      `DBC_SZ_WORD: sel = addr_lo_in[1] ? 4'h3 : 4'hC;
      default:      sel = 4'hF;
    endcase
  end

  // an enabled lane must equal the operand's lanes exactly; all selected bytes must match
  always_comb
  begin
    en = (lane_en_in[6] & (sel == 4'hF))
       | (lane_en_in[5] & (sel == 4'h3)) | (lane_en_in[4] & (sel == 4'hC))
       | (lane_en_in[3] & (sel == 4'h1)) | (lane_en_in[2] & (sel == 4'h2))
       | (lane_en_in[1] & (sel == 4'h4)) | (lane_en_in[0] & (sel == 4'h8));
    eq = &(byte_eq | ~sel);
    hit_out = en & (eq ^ invert_in);
  end
endmodule : dbc_data_lane

// ### dbc_pkg.sv
// types for the debug breakpoint comparator block
// assumes dbc_cfg.svh is in the include path
`include "dbc_cfg.svh"
package dbc_pkg;
  // registered state of the top module
  typedef struct packed {
    logic [31:0] pc_addr;
    logic [31:0] pc_mask;
    logic [31:0] data_val;
    logic [31:0] data_mask;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic        pc_hit;
    logic        data_hit;
  } dbc_state_t;
endpackage : dbc_pkg

// ### dbc_tb.sv
// self-checking bench of the pc and data breakpoint comparator
// assumes dbc_cfg.svh in the include path, bus model drives the pc side
`timescale 1ns/100ps
module tb;
  typedef struct {logic [9:0] td; logic pv; logic [31:0] pc; logic bv;
    logic [31:0] d; logic [1:0] a; logic [1:0] sz; logic ep; logic ed;} dbc_row_t;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, sw_wr_in = 1'b0, dbg_wr_in = 1'b0;
  logic        dbg_rd_in = 1'b0, dbg_mem_in = 1'b0, rd_v, pc_hit, data_hit, pcv, bv;
  logic [3:0]  sw_reg_in = 4'h0, dbg_reg_in = 4'h0;
  logic [31:0] sw_data_in = 32'h0, dbg_data_in = 32'h0, mem_d = 32'h0, rd_data, pc, bd;
  logic [9:0]  td = 10'h000;
  logic [1:0]  alo, sz;
  int          err_total = 0, samples_checked = 0;
  dbc_row_t    rows [14] = '{
    '{10'h002, 1'b1, 32'h123456AA, 1'b0, 32'h0, 2'h0, 2'h0, 1'b1, 1'b0},
    '{10'h002, 1'b1, 32'h133456AA, 1'b0, 32'h0, 2'h0, 2'h0, 1'b0, 1'b0},
    '{10'h003, 1'b1, 32'h133456AA, 1'b0, 32'h0, 2'h0, 2'h0, 1'b1, 1'b0},
    '{10'h000, 1'b1, 32'h12345600, 1'b0, 32'h0, 2'h0, 2'h0, 1'b0, 1'b0},
    '{10'h200, 1'b0, 32'h0, 1'b1, 32'hAABBCCDD, 2'h0, 2'h0, 1'b0, 1'b1},
    '{10'h204, 1'b0, 32'h0, 1'b1, 32'hAABBCCDD, 2'h0, 2'h0, 1'b0, 1'b0},
    '{10'h204, 1'b0, 32'h0, 1'b1, 32'h00BBCCDD, 2'h0, 2'h0, 1'b0, 1'b1},
    '{10'h080, 1'b0, 32'h0, 1'b1, 32'hAABB1234, 2'h1, 2'h2, 1'b0, 1'b1},
    '{10'h100, 1'b0, 32'h0, 1'b1, 32'h5678CCDD, 2'h2, 2'h2, 1'b0, 1'b1},
    '{10'h008, 1'b0, 32'h0, 1'b1, 32'hAA000000, 2'h0, 2'h1, 1'b0, 1'b1},
    '{10'h010, 1'b0, 32'h0, 1'b1, 32'h00BB0000, 2'h1, 2'h1, 1'b0, 1'b1},
    '{10'h040, 1'b0, 32'h0, 1'b1, 32'h0000DD00, 2'h2, 2'h1, 1'b0, 1'b0},
    '{10'h080, 1'b0, 32'h0, 1'b1, 32'hAABBCCDD, 2'h2, 2'h2, 1'b0, 1'b0},
    '{10'h000, 1'b0, 32'h0, 1'b1, 32'hAABBCCDD, 2'h0, 2'h0, 1'b0, 1'b0}
  };
  ////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  dbc_bus_model m (.clk_in(clk_in), .pc_valid_out(pcv), .pc_out(pc), .bus_valid_out(bv),
    .bus_data_out(bd), .bus_addr_lo_out(alo), .bus_size_out(sz));
  dbc_break_cmp uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sw_wr_in(sw_wr_in),
    .sw_reg_in(sw_reg_in), .sw_data_in(sw_data_in), .dbg_wr_in(dbg_wr_in), .dbg_rd_in(dbg_rd_in),
    .dbg_reg_in(dbg_reg_in), .dbg_data_in(dbg_data_in), .dbg_rd_data_out(rd_data),
    .dbg_rd_valid_out(rd_v), .dbg_mem_in(dbg_mem_in), .dbg_mem_data_in(mem_d),
    .trigger_definition_in(td), .pc_valid_in(pcv), .pc_in(pc), .bus_valid_in(bv),
    .bus_data_in(bd), .bus_addr_lo_in(alo), .bus_size_in(sz), .pc_hit_out(pc_hit),
    .data_hit_out(data_hit));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // register write, one cycle strobe from a falling edge
  task automatic wr(input logic dbg, input logic [3:0] r, input logic [31:0] d);
    @(negedge clk_in);
    if (dbg)
      {dbg_wr_in, dbg_reg_in, dbg_data_in} = {1'b1, r, d};
    else
      {sw_wr_in, sw_reg_in, sw_data_in} = {1'b1, r, d};
    @(negedge clk_in);
    {sw_wr_in, dbg_wr_in} = 2'h0;
  endtask : wr
  task automatic rd(input logic [3:0] r, input logic [31:0] e);
    @(negedge clk_in);
    {dbg_rd_in, dbg_reg_in} = {1'b1, r};
    @(negedge clk_in);
    dbg_rd_in = 1'b0;
    chk("rd_valid", {31'h0, rd_v}, 32'h1);
    chk("rd_data", rd_data, e);
    @(negedge clk_in);
    chk("rd_valid drop", {31'h0, rd_v}, 32'h0);
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////
  // main sequence: reset, program before enabling, table, then odd cases
  initial
  begin
    repeat (8) @(negedge clk_in);
    chk("reset rd_data", rd_data, 32'h0);
    chk("reset flags", {29'h0, rd_v, pc_hit, data_hit}, 32'h0);
    sys_rst_in = 1'b0;
    wr(1'b0, 4'h8, 32'h12345678);
    wr(1'b1, 4'h9, 32'h000000FF);
    wr(1'b0, 4'hE, 32'hAABBCCDD);
    wr(1'b1, 4'hF, 32'h00000000);
    foreach (rows[i])
    begin
      td = rows[i].td;
      m.xfer(rows[i].pv, rows[i].pc, rows[i].bv, rows[i].d, rows[i].a, rows[i].sz);
      chk("pc_hit", {31'h0, pc_hit}, {31'h0, rows[i].ep});
      chk("data_hit", {31'h0, data_hit}, {31'h0, rows[i].ed});
    end
    rd(4'h8, 32'h12345678);
    rd(4'h9, 32'h0);
    rd(4'hF, 32'h0);
    // debugger memory access beats a same-cycle software write
    {dbg_mem_in, mem_d, sw_wr_in, sw_reg_in, sw_data_in} = {1'b1, 32'h11223344, 1'b1, 4'hE, 32'h55};
    @(negedge clk_in);
    {dbg_mem_in, sw_wr_in} = 2'h0;
    rd(4'hE, 32'h11223344);
    td = 10'h200;
    m.xfer(1'b0, 32'h0, 1'b1, 32'h11223344, 2'h0, 2'h0);
    chk("data_hit mem", {31'h0, data_hit}, 32'h1);
    // software beats the debugger on a same-cycle write
    @(negedge clk_in);
    {sw_wr_in, sw_reg_in, sw_data_in} = {1'b1, 4'h8, 32'h87654321};
    {dbg_wr_in, dbg_reg_in, dbg_data_in} = {1'b1, 4'h8, 32'h0F0F0F0F};
    @(negedge clk_in);
    {sw_wr_in, dbg_wr_in} = 2'h0;
    rd(4'h8, 32'h87654321);
    // debugger writes, one of them to a number that holds nothing
    wr(1'b1, 4'h8, 32'h00000004);
    wr(1'b1, 4'h3, 32'hFFFFFFFF);
    wr(1'b1, 4'hE, 32'h0A0B0C0D);
    rd(4'h8, 32'h00000004);
    rd(4'hE, 32'h0A0B0C0D);
    rd(4'h3, 32'h0);
    // an all-ones pc mask lets any pc hit
    wr(1'b0, 4'h9, 32'hFFFFFFFF);
    td = 10'h002;
    m.xfer(1'b1, 32'hFFFF0000, 1'b0, 32'h0, 2'h0, 2'h0);
    chk("pc_hit masked", {31'h0, pc_hit}, 32'h1);
    // software-written data mask drops the low byte only
    wr(1'b0, 4'hF, 32'h000000FF);
    td = 10'h200;
    m.xfer(1'b0, 32'h0, 1'b1, 32'h0A0B0C77, 2'h0, 2'h0);
    chk("data_hit masked", {31'h0, data_hit}, 32'h1);
    m.xfer(1'b0, 32'h0, 1'b1, 32'h1A0B0C0D, 2'h0, 2'h0);
    chk("data_hit unmasked", {31'h0, data_hit}, 32'h0);
    // reset in mid-run clears outputs and registers
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("mid reset flags", {29'h0, rd_v, pc_hit, data_hit}, 32'h0);
    sys_rst_in = 1'b0;
    rd(4'h8, 32'h0);
    end_of_test();
  end
  // watchdog well beyond the hundred or so cycles needed
  initial
  begin
    #(100 * 2000);
    err_total++;
    end_of_test();
  end
endmodule : tb
